/* File: core/pbh_defs.svh */
// Constants for the primary bus hold interface
`ifndef PBH_DEFS_SVH
`define PBH_DEFS_SVH
`define PBH_DATA_W 32
`define PBH_ADDR_W 24
`define PBH_WAIT_W 3
`define PBH_CLK_NS 50
`define PBH_RESET_VECTOR 24'h00_0000
`define PBH_ZERO_ADDR 24'h00_0000
`define PBH_ZERO_DATA 32'h0000_0000
`define PBH_ZERO_WAIT 3'h0
`define PBH_ONE_WAIT 3'h1
`define PBH_SYNC_IDLE 3'h7
`endif

/* File: core/pbh_pkg.sv */
// Types for the primary bus hold interface
package pbh_pkg;
    typedef enum logic [2:0] {
        PBH_RESET = 3'h0,
        PBH_IDLE = 3'h1,
        PBH_ACCESS = 3'h2,
        PBH_WAIT_RDY = 3'h3,
        PBH_HELD = 3'h4
    } pbh_state_type;
endpackage

/* File: core/pbh_bus.sv */
// Primary bus interface with hold handshake, reset start and shutdown
`timescale 1ns/1ns
`include "pbh_defs.svh"
// Notes on behaviour
// R1: Data bus is 32 bits, address bus 24 bits, every access.
// R2: Read/write line high for reads, low for writes.
// R3: Access does not finish until the ready input signals completion.
// R4: Wait states come from a programmed count and from ready.
// R5: Low hold request: finish current transfer, then float bus lines.
// R6: While held, no new transfers until request high or ignore bit set.
// R7: Acknowledge goes low in answer to a low hold request.
// R8: Acknowledge high when request high or ignore bit set.
// R9: Held in reset while reset low; starts fetching at reset vector.
// R10: Shutdown floats every output and stops operation.
// R11: Outside party must reset with shutdown inactive after shutdown.
// R12: Service marker pulses only for the acknowledge instruction.
// R13: Two bus clocks at half input clock; floated during shutdown.
// R14: In reset, address, data, read/write float; strobe driven high.
// R15: Hold request and ready sampled on the clock; strobe held until ready.
module pbh_bus (
    input wire logic clk,
    input wire logic nrst,
    input wire logic pin_float_shutdown_n,
    input wire logic hold_request_n,
    input wire logic ready_n,
    input wire logic ignore_bus_request_bit,
    input wire logic [`PBH_WAIT_W-1:0] wait_count,
    input wire logic core_req,
    input wire logic core_write,
    input wire logic [`PBH_ADDR_W-1:0] core_addr,
    input wire logic [`PBH_DATA_W-1:0] core_wdata,
    input wire logic core_ack_instr,
    output logic core_done,
    output logic [`PBH_DATA_W-1:0] core_rdata,
    output logic fetch_start,
    output logic [`PBH_ADDR_W-1:0] fetch_addr,
    output logic [`PBH_ADDR_W-1:0] address_bus_out,
    output logic address_bus_oe,
    input wire logic [`PBH_DATA_W-1:0] data_bus_in,
    output logic [`PBH_DATA_W-1:0] data_bus_out,
    output logic data_bus_oe,
    output logic access_strobe_n,
    output logic access_strobe_oe,
    output logic read_write,
    output logic read_write_oe,
    output logic bus_release_ack_n,
    output logic bus_release_ack_oe,
    output logic service_marker_out_n,
    output logic service_marker_oe,
    output logic bus_clock_out_a,
    output logic bus_clock_out_a_oe,
    output logic bus_clock_out_b,
    output logic bus_clock_out_b_oe
);
    import pbh_pkg::*;

    pbh_state_type state;
    pbh_state_type next_state;
    logic [2:0] shz_sync;
    logic [2:0] hold_sync;
    logic [2:0] rdy_sync;
    logic shz_n;
    logic hold_n;
    logic rdy_n;
    logic [`PBH_WAIT_W-1:0] wait_left;
    logic [`PBH_ADDR_W-1:0] addr_q;
    logic [`PBH_DATA_W-1:0] wdata_q;
    logic write_q;
    logic clk_div;
    logic marker;
    logic started;

    // Synchronisers: change taken once stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shz_sync <= `PBH_SYNC_IDLE;
            hold_sync <= `PBH_SYNC_IDLE;
            rdy_sync <= `PBH_SYNC_IDLE;
            shz_n <= 1'b1;
            hold_n <= 1'b1;
            rdy_n <= 1'b1;
        end else begin
            shz_sync <= {shz_sync[1:0], pin_float_shutdown_n};
            hold_sync <= {hold_sync[1:0], hold_request_n};
            rdy_sync <= {rdy_sync[1:0], ready_n};
            if (shz_sync[1] == shz_sync[2]) shz_n <= shz_sync[2];
            if (hold_sync[1] == hold_sync[2]) hold_n <= hold_sync[2]; // R15
            if (rdy_sync[1] == rdy_sync[2]) rdy_n <= rdy_sync[2]; // R15
        end
    end

    wire shut = !shz_n;
    wire hold_wanted = !hold_n && !ignore_bus_request_bit;
    wire wait_done = (wait_left == `PBH_ZERO_WAIT);
    wire access_end = (state == PBH_WAIT_RDY) && !rdy_n; // R3
    wire in_access = (state == PBH_ACCESS) || (state == PBH_WAIT_RDY);
    wire drive_bus = !shut && (state != PBH_RESET) && (state != PBH_HELD);

    always_comb begin
        next_state = state;
        case (state)
            PBH_RESET: next_state = PBH_IDLE; // R9
            PBH_IDLE: begin
                if (hold_wanted) next_state = PBH_HELD; // R5
                else if (core_req) next_state = PBH_ACCESS;
            end
            PBH_ACCESS: if (wait_done) next_state = PBH_WAIT_RDY; // R4
            PBH_WAIT_RDY: if (!rdy_n) next_state = PBH_IDLE; // R3
            PBH_HELD: if (!hold_wanted) next_state = PBH_IDLE; // R6
            default: next_state = PBH_IDLE;
        endcase
        if (shut) next_state = PBH_RESET; // R10
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) state <= PBH_RESET; // R9
        else state <= next_state;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_left <= `PBH_ZERO_WAIT;
            addr_q <= `PBH_ZERO_ADDR;
            wdata_q <= `PBH_ZERO_DATA;
            write_q <= 1'b0;
        end else if (state == PBH_IDLE && next_state == PBH_ACCESS) begin
            wait_left <= wait_count; // R4
            addr_q <= core_addr; // R1
            wdata_q <= core_wdata;
            write_q <= core_write;
        end else if (state == PBH_ACCESS && !wait_done) begin
            wait_left <= wait_left - `PBH_ONE_WAIT; // R4
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            core_done <= 1'b0;
            core_rdata <= `PBH_ZERO_DATA;
            clk_div <= 1'b0;
            marker <= 1'b0;
            started <= 1'b0;
            fetch_start <= 1'b0;
        end else begin
            core_done <= access_end && !shut;
            if (access_end && !write_q) core_rdata <= data_bus_in; // R1
            clk_div <= !clk_div; // R13
            marker <= core_ack_instr && !shut; // R12
            fetch_start <= (state == PBH_RESET) && !started && !shut; // R9
            if (state == PBH_RESET && !shut) started <= 1'b1;
        end
    end

    assign fetch_addr = `PBH_RESET_VECTOR; // R9
    assign address_bus_out = addr_q;
    assign address_bus_oe = drive_bus; // R5 R14
    assign data_bus_out = wdata_q;
    assign data_bus_oe = drive_bus && in_access && write_q; // R5
    assign access_strobe_n = !in_access; // R15
    assign access_strobe_oe = !shut && (state != PBH_HELD); // R14
    assign read_write = !write_q || !in_access; // R2
    assign read_write_oe = drive_bus; // R5
    assign bus_release_ack_n = (state != PBH_HELD); // R7 R8
    assign bus_release_ack_oe = !shut; // R10
    assign service_marker_out_n = !marker; // R12
    assign service_marker_oe = !shut; // R10
    assign bus_clock_out_a = clk_div; // R13
    assign bus_clock_out_b = !clk_div; // R13
    assign bus_clock_out_a_oe = !shut; // R13
    assign bus_clock_out_b_oe = !shut; // R13

    property p_held_floats;
        @(posedge clk) disable iff (!nrst)
        !bus_release_ack_n |-> !address_bus_oe && !data_bus_oe
            && !access_strobe_oe && !read_write_oe;
    endproperty
    a_held_floats: assert property (p_held_floats) // R5
        else $error("bus driven while acknowledged");

    property p_no_drop_access;
        @(posedge clk) disable iff (!nrst)
        in_access && !shut |=> in_access || core_done || shut;
    endproperty
    a_no_drop_access: assert property (p_no_drop_access) // R5
        else $error("access abandoned before completion");

    property p_strobe_until_ready;
        @(posedge clk) disable iff (!nrst)
        state == PBH_WAIT_RDY && rdy_n && !shut |=> !access_strobe_n;
    endproperty
    a_strobe_until_ready: assert property (p_strobe_until_ready) // R15
        else $error("strobe dropped before ready");

    property p_done_needs_ready;
        @(posedge clk) disable iff (!nrst)
        core_done |-> $past(!rdy_n) && $past(state == PBH_WAIT_RDY);
    endproperty
    a_done_needs_ready: assert property (p_done_needs_ready) // R3
        else $error("access done without ready");

    property p_rw_level;
        @(posedge clk) disable iff (!nrst)
        in_access |-> read_write == !write_q;
    endproperty
    a_rw_level: assert property (p_rw_level) // R2
        else $error("read/write level wrong");

    property p_wait_states;
        @(posedge clk) disable iff (!nrst)
        state == PBH_IDLE && next_state == PBH_ACCESS
            && wait_count == 3'h2 ##1 !shut [*2]
            |-> state == PBH_ACCESS;
    endproperty
    a_wait_states: assert property (p_wait_states) // R4
        else $error("programmed wait states skipped");

    property p_ack_release;
        @(posedge clk) disable iff (!nrst)
        state == PBH_HELD && (hold_n || ignore_bus_request_bit) && !shut
            |=> bus_release_ack_n;
    endproperty
    a_ack_release: assert property (p_ack_release) // R8
        else $error("acknowledge not released");

    property p_no_new_when_held;
        @(posedge clk) disable iff (!nrst)
        state == PBH_HELD |=> state != PBH_ACCESS;
    endproperty
    a_no_new_when_held: assert property (p_no_new_when_held) // R6
        else $error("transfer started while held");

    property p_ack_grant;
        @(posedge clk) disable iff (!nrst)
        state == PBH_IDLE && hold_wanted && !shut |=> !bus_release_ack_n;
    endproperty
    a_ack_grant: assert property (p_ack_grant) // R7
        else $error("acknowledge not granted");

    property p_shut_float;
        @(posedge clk) disable iff (!nrst)
        shut |-> !bus_clock_out_a_oe && !service_marker_oe
            && !access_strobe_oe && !bus_release_ack_oe;
    endproperty
    a_shut_float: assert property (p_shut_float) // R10
        else $error("pin driven during shutdown");

    property p_clock_toggle;
        @(posedge clk) disable iff (!nrst)
        1'b1 |=> bus_clock_out_a != $past(bus_clock_out_a);
    endproperty
    a_clock_toggle: assert property (p_clock_toggle) // R13
        else $error("bus clock not toggling");

    property p_reset_strobe;
        @(posedge clk) disable iff (!nrst)
        state == PBH_RESET && !shut |-> access_strobe_oe && access_strobe_n
            && !address_bus_oe && !data_bus_oe && !read_write_oe;
    endproperty
    a_reset_strobe: assert property (p_reset_strobe) // R14
        else $error("reset pin levels wrong");

    property p_fetch_pulse;
        @(posedge clk) disable iff (!nrst)
        fetch_start |-> $past(state == PBH_RESET) ##1 !fetch_start;
    endproperty
    a_fetch_pulse: assert property (p_fetch_pulse) // R9
        else $error("fetch start not a single pulse");

    property p_marker_pulse;
        @(posedge clk) disable iff (!nrst)
        !service_marker_out_n |-> $past(core_ack_instr);
    endproperty
    a_marker_pulse: assert property (p_marker_pulse) // R12
        else $error("marker without acknowledge instruction");

    property p_addr_stable;
        @(posedge clk) disable iff (!nrst)
        in_access ##1 in_access
            |-> $stable(address_bus_out) && $stable(read_write);
    endproperty
    a_addr_stable: assert property (p_addr_stable) // R1
        else $error("address changed inside access");

    property p_shut_idle;
        @(posedge clk) disable iff (!nrst)
        shut |=> !in_access && bus_release_ack_n;
    endproperty
    a_shut_idle: assert property (p_shut_idle) // R10
        else $error("bus activity during shutdown");

    property p_ready_ends;
        @(posedge clk) disable iff (!nrst)
        state == PBH_WAIT_RDY && !rdy_n && !shut |=> core_done
            && access_strobe_n;
    endproperty
    a_ready_ends: assert property (p_ready_ends) // R3
        else $error("access not ended on ready");

    c_read: cover property (@(posedge clk) disable iff (!nrst)
        core_done && !write_q);
    c_write: cover property (@(posedge clk) disable iff (!nrst)
        core_done && write_q);
    c_hold: cover property (@(posedge clk) disable iff (!nrst)
        !bus_release_ack_n ##1 bus_release_ack_n);
    c_shut: cover property (@(posedge clk) disable iff (!nrst) shut);
    c_wait_state: cover property (@(posedge clk) disable iff (!nrst)
        state == PBH_ACCESS ##1 state == PBH_ACCESS);
endmodule // pbh_bus

/* File: tb/pbh_mem.sv */
// Far-side memory model answering with a programmable ready delay
`timescale 1ns/1ns
module pbh_mem (
    input wire logic clk,
    input wire logic strobe_n,
    input wire logic rw,
    input wire logic [23:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [3:0] delay,
    output logic ready_n,
    output logic [31:0] rdata
);
    logic [31:0] mem [16];
    logic [3:0] cnt;
    initial begin
        ready_n = 1'b1;
        rdata = 32'h0000_0000;
        cnt = 4'h0;
    end
    always @(posedge clk) begin
        if (strobe_n) begin
            cnt <= 4'h0;
            ready_n <= 1'b1;
            rdata <= ~rdata; // Released bus keeps changing
        end else begin
            cnt <= cnt + 4'h1;
            ready_n <= !(cnt >= delay);
            if (rw) rdata <= mem[addr[3:0]];
            else mem[addr[3:0]] <= wdata;
        end
    end
endmodule // pbh_mem

/* File: tb/primary_bus_hold_interface_test.sv */
// Testbench for the primary bus hold interface
`timescale 1ns/1ns
`include "pbh_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[FAIL] %0t mismatch", $time); end end
module primary_bus_hold_interface_test;
    logic clk, nrst, shz_n, hold_n, rdy_n, ign, req, wr, ack_i;
    logic [2:0] wcnt;
    logic [3:0] dly;
    logic [23:0] addr, a_out, f_addr;
    logic [31:0] wdat, rdat, d_in, d_out, q;
    logic done, fst, a_oe, d_oe, s_n, s_oe, rw, rw_oe, k_n, k_oe, m_n, m_oe;
    logic ca, ca_oe, cb, cb_oe;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    pbh_bus DUT (.clk(clk), .nrst(nrst), .pin_float_shutdown_n(shz_n),
        .hold_request_n(hold_n), .ready_n(rdy_n), .ignore_bus_request_bit(ign),
        .wait_count(wcnt), .core_req(req), .core_write(wr), .core_addr(addr),
        .core_wdata(wdat), .core_ack_instr(ack_i), .core_done(done),
        .core_rdata(rdat), .fetch_start(fst), .fetch_addr(f_addr),
        .address_bus_out(a_out), .address_bus_oe(a_oe), .data_bus_in(d_in),
        .data_bus_out(d_out), .data_bus_oe(d_oe), .access_strobe_n(s_n),
        .access_strobe_oe(s_oe), .read_write(rw), .read_write_oe(rw_oe),
        .bus_release_ack_n(k_n), .bus_release_ack_oe(k_oe),
        .service_marker_out_n(m_n), .service_marker_oe(m_oe),
        .bus_clock_out_a(ca), .bus_clock_out_a_oe(ca_oe),
        .bus_clock_out_b(cb), .bus_clock_out_b_oe(cb_oe));
    pbh_mem MEM (.clk(clk), .strobe_n(s_n), .rw(rw), .addr(a_out),
        .wdata(d_out), .delay(dly), .ready_n(rdy_n), .rdata(d_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic end_sim();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            end_sim();
        end
    end
    task automatic t_reset();
        @(posedge clk);
        nrst <= 1'b0;
        shz_n <= 1'b1;
        repeat (2) @(negedge clk);
        `CHK({s_oe, s_n, a_oe, d_oe, rw_oe}, 5'b11000)
        @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(negedge clk) if (fst === 1'b1) break;
        `CHK(fst, 1'b1)
        `CHK(f_addr, `PBH_RESET_VECTOR)
        repeat (4) @(negedge clk);
    endtask
    task automatic t_acc(logic w, logic [23:0] a, logic [31:0] d,
            logic [2:0] ws, logic [3:0] dl, logic h);
        int n;
        int low;
        n = 0;
        low = 0;
        @(posedge clk);
        req <= 1'b1;
        wr <= w;
        addr <= a;
        wdat <= d;
        wcnt <= ws;
        dly <= dl;
        if (h) hold_n <= 1'b0;
        @(posedge clk);
        req <= 1'b0;
        while (done !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
            if (s_n === 1'b0) begin
                low++;
                `CHK({rw, rw_oe, d_oe}, {!w, 1'b1, w})
                `CHK(a_out, a)
                if (w) `CHK(d_out, d)
            end
        end
        `CHK(done, 1'b1)
        `CHK(low > ws && low > dl, 1'b1)
        if (h) `CHK(k_n, 1'b1)
        q = rdat;
        repeat (6) @(negedge clk);
    endtask
    task automatic t_hold();
        t_acc(1'b0, 24'h00_0005, 32'h0000_0000, 3'h0, 4'h8, 1'b1);
        repeat (3) @(negedge clk);
        `CHK({k_n, k_oe, a_oe, d_oe, s_oe, rw_oe}, 6'b010000)
        @(posedge clk);
        req <= 1'b1;
        repeat (8) @(negedge clk) `CHK({s_oe, done}, 2'b00);
        @(posedge clk);
        ign <= 1'b1;
        repeat (3) @(negedge clk);
        `CHK(k_n, 1'b1)
        `CHK(s_n, 1'b0)
        @(posedge clk);
        req <= 1'b0;
        repeat (20) @(negedge clk) if (done === 1'b1) break;
        `CHK(done, 1'b1)
        @(posedge clk);
        hold_n <= 1'b1;
        repeat (30) @(negedge clk);
        @(posedge clk);
        ign <= 1'b0;
    endtask
    task automatic t_misc();
        @(posedge clk);
        ack_i <= 1'b1;
        @(posedge clk);
        ack_i <= 1'b0;
        repeat (4) @(negedge clk) if (m_n === 1'b0) break;
        `CHK({m_n, m_oe}, 2'b01)
        @(negedge clk);
        `CHK(m_n, 1'b1)
        q[0] = ca;
        @(negedge clk);
        `CHK({ca, cb, ca_oe, cb_oe}, {!q[0], q[0], 2'b11})
        @(posedge clk);
        shz_n <= 1'b0;
        repeat (6) @(negedge clk);
        `CHK({a_oe, d_oe, s_oe, rw_oe, k_oe, m_oe, ca_oe, cb_oe}, 8'h00)
    endtask
    initial begin
        {nrst, shz_n, hold_n, ign, req, wr, ack_i} = 7'b0110000;
        wcnt = 3'h0;
        dly = 4'h0;
        addr = 24'h00_0000;
        wdat = 32'h0000_0000;
        t_reset();
        t_acc(1'b1, 24'h00_0005, 32'hA5A5_5A5A, 3'h7, 4'h0, 1'b0);
        t_acc(1'b1, 24'hFF_FFF6, 32'h1234_8765, 3'h0, 4'h3, 1'b0);
        t_acc(1'b0, 24'hFF_FFF6, 32'h0000_0000, 3'h2, 4'h0, 1'b0);
        `CHK(q, 32'h1234_8765)
        t_acc(1'b0, 24'h00_0005, 32'h0000_0000, 3'h0, 4'h9, 1'b0);
        `CHK(q, 32'hA5A5_5A5A)
        t_hold();
        t_misc();
        t_reset();
        t_acc(1'b0, 24'h00_0005, 32'h0000_0000, 3'h1, 4'h1, 1'b0);
        `CHK(q, 32'hA5A5_5A5A)
        end_sim();
    end
endmodule // primary_bus_hold_interface_test
